// *** common/scs_cfg.svh ***
// Constants of the scan compare sequencer
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
// ==========================================
// Register byte offsets
`define SCS_ADDR_W 8
`define SCS_OFS_CTRL 8'h00
`define SCS_OFS_CHANCNT 8'h04
`define SCS_OFS_DELAY 8'h08
`define SCS_OFS_REF 8'h0c
`define SCS_OFS_HILIM 8'h10
`define SCS_OFS_LOLIM 8'h14
`define SCS_OFS_STATUS 8'h18
// ==========================================
// Control bit positions
`define SCS_CTRL_EN 0
`define SCS_CTRL_FALL 1
`define SCS_CTRL_MODE 2
`define SCS_CTRL_START 3
// ==========================================
// Status field positions
`define SCS_ST_BUSY 0
`define SCS_ST_PASS 1
`define SCS_ST_LOW 2
`define SCS_ST_HIGH 3
`define SCS_ST_CHAN_LSB 8
// ==========================================
// Ranges, reset values, clock rate and scale factors
`define SCS_CHAN_MIN 32'h0000_0001
`define SCS_CHAN_MAX 32'h0000_0064
`define SCS_DELAY_MIN_MS 32'h0000_0190
`define SCS_DELAY_MAX_MS 32'h0000_7530
`define SCS_CLK_HZ 10000000
`define SCS_MS_PER_S 1000
`define SCS_PCT_SCALE 66'sh64
// ==========================================
// Link side pulse and settle time in link cycles
`define SCS_LINK_HOLD 4'h4
`endif

// *** common/scs_pkg.sv ***
// Types of the scan compare sequencer
package scs_pkg;
    typedef enum logic [2:0] {
        SQ_IDLE,
        SQ_DELAY,
        SQ_MEAS,
        SQ_GRADE,
        SQ_SEND,
        SQ_WAIT
    } scs_seq_e;

    typedef enum logic [2:0] {
        LK_IDLE,
        LK_SETTLE,
        LK_CLKHI,
        LK_CLKLO,
        LK_SCAN_DONE_PULSE,
        LK_ACK
    } scs_lnk_e;
endpackage : scs_pkg

// *** core/scs_scan_seq.sv ***
// Scan compare sequencer: registers, channel sequence, grading, handler link
`timescale 1ns/1ns
`include "scs_cfg.svh"

module scs_scan_seq
    import scs_pkg::*;
#(
    parameter int CYC_PER_MS = `SCS_CLK_HZ / `SCS_MS_PER_S,
    parameter int CYC_W = 16
) (
    // System
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [`SCS_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // Measurement front end
    output logic measReq,
    output logic [6:0] measChan,
    input wire logic [31:0] measData,
    input wire logic measValid,
    // Handler link
    input wire logic linkClk,
    input wire logic trigPin,
    output logic scanOe,
    output logic relayOut,
    output logic passOut,
    output logic lowOut,
    output logic highOut,
    output logic groupClk,
    output logic scanDonePulse
);

    function automatic logic [31:0] clampVal(input logic [31:0] v,
                                             input logic [31:0] lo,
                                             input logic [31:0] hi);
        clampVal = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clampVal

    // ==========================================
    // Registers
    logic enable_ff, nxt_enable;
    logic fallEdge_ff, nxt_fallEdge;
    logic modePct_ff, nxt_modePct;
    logic [6:0] chanCnt_ff, nxt_chanCnt;
    logic [14:0] delayMs_ff, nxt_delayMs;
    logic [31:0] ref_ff, nxt_ref;
    logic [31:0] hiLim_ff, nxt_hiLim;
    logic [31:0] loLim_ff, nxt_loLim;
    logic [31:0] rdData_ff, nxt_rdData;
    logic manStart;
    logic [31:0] chanClamp;
    logic [31:0] delayClamp;

    // Sequencer state
    scs_seq_e seq_ff, nxt_seq;
    logic [6:0] chan_ff, nxt_chan;
    logic [14:0] msCnt_ff, nxt_msCnt;
    logic [CYC_W-1:0] cyc_ff, nxt_cyc;
    logic [31:0] meas_ff, nxt_meas;
    logic req_ff, nxt_req;
    logic measReq_ff, nxt_measReq;
    logic [4:0] word_ff, nxt_word;
    logic [2:0] grade_ff, nxt_grade;

    // Crossing flops in the clk domain
    logic trgS1_ff, trgS2_ff, trgS3_ff;
    logic ackS1_ff, ackS2_ff;
    logic trigEvt;
    logic pending;

    always_comb begin
        chanClamp = clampVal({25'h0, regWrData[6:0]}, `SCS_CHAN_MIN, `SCS_CHAN_MAX);
        delayClamp = clampVal({17'h0, regWrData[14:0]}, `SCS_DELAY_MIN_MS,
                              `SCS_DELAY_MAX_MS);
        nxt_enable = enable_ff;
        nxt_fallEdge = fallEdge_ff;
        nxt_modePct = modePct_ff;
        nxt_chanCnt = chanCnt_ff;
        nxt_delayMs = delayMs_ff;
        nxt_ref = ref_ff;
        nxt_hiLim = hiLim_ff;
        nxt_loLim = loLim_ff;
        manStart = 1'b0;
        if (regWr) begin
            case (regAddr)
                `SCS_OFS_CTRL: begin
                    nxt_enable = regWrData[`SCS_CTRL_EN];
                    nxt_fallEdge = regWrData[`SCS_CTRL_FALL];
                    if (regWrData[`SCS_CTRL_MODE]) begin
                        nxt_modePct = ~modePct_ff;
                    end
                    manStart = regWrData[`SCS_CTRL_START];
                end
                `SCS_OFS_CHANCNT: nxt_chanCnt = chanClamp[6:0];
                `SCS_OFS_DELAY: nxt_delayMs = delayClamp[14:0];
                `SCS_OFS_REF: nxt_ref = regWrData;
                `SCS_OFS_HILIM: nxt_hiLim = regWrData;
                `SCS_OFS_LOLIM: nxt_loLim = regWrData;
                default: ;
            endcase
        end
        nxt_rdData = 32'h0;
        if (regRd) begin
            case (regAddr)
                `SCS_OFS_CTRL: begin
                    nxt_rdData[`SCS_CTRL_EN] = enable_ff;
                    nxt_rdData[`SCS_CTRL_FALL] = fallEdge_ff;
                    nxt_rdData[`SCS_CTRL_MODE] = modePct_ff;
                end
                `SCS_OFS_CHANCNT: nxt_rdData = {25'h0, chanCnt_ff};
                `SCS_OFS_DELAY: nxt_rdData = {17'h0, delayMs_ff};
                `SCS_OFS_REF: nxt_rdData = ref_ff;
                `SCS_OFS_HILIM: nxt_rdData = hiLim_ff;
                `SCS_OFS_LOLIM: nxt_rdData = loLim_ff;
                `SCS_OFS_STATUS: begin
                    nxt_rdData[`SCS_ST_BUSY] = (seq_ff != SQ_IDLE);
                    nxt_rdData[`SCS_ST_HIGH:`SCS_ST_PASS] = grade_ff;
                    nxt_rdData[`SCS_ST_CHAN_LSB+6:`SCS_ST_CHAN_LSB] = chan_ff;
                end
                default: nxt_rdData = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enable_ff <= 1'b0;
            fallEdge_ff <= 1'b0;
            modePct_ff <= 1'b0;
            chanCnt_ff <= 7'(`SCS_CHAN_MAX);
            delayMs_ff <= 15'(`SCS_DELAY_MIN_MS);
            ref_ff <= 32'h0;
            hiLim_ff <= 32'h0;
            loLim_ff <= 32'h0;
            rdData_ff <= 32'h0;
        end else begin
            enable_ff <= nxt_enable;
            fallEdge_ff <= nxt_fallEdge;
            modePct_ff <= nxt_modePct;
            chanCnt_ff <= nxt_chanCnt;
            delayMs_ff <= nxt_delayMs;
            ref_ff <= nxt_ref;
            hiLim_ff <= nxt_hiLim;
            loLim_ff <= nxt_loLim;
            rdData_ff <= nxt_rdData;
        end
    end

    assign regRdData = rdData_ff;

    // ==========================================
    // Crossing into clk domain
    logic trigTgl_ff;
    logic ackTgl_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trgS1_ff <= 1'b0;
            trgS2_ff <= 1'b0;
            trgS3_ff <= 1'b0;
            ackS1_ff <= 1'b0;
            ackS2_ff <= 1'b0;
        end else begin
            trgS1_ff <= trigTgl_ff;
            trgS2_ff <= trgS1_ff;
            trgS3_ff <= trgS2_ff;
            ackS1_ff <= ackTgl_ff;
            ackS2_ff <= ackS1_ff;
        end
    end

    assign trigEvt = trgS2_ff ^ trgS3_ff;
    assign pending = req_ff ^ ackS2_ff;

    // ==========================================
    // Grading
    logic signed [65:0] devX, hiX, loX;
    logic isLow, isHigh;

    always_comb begin
        devX = ($signed({34'h0, meas_ff}) - $signed({34'h0, ref_ff})) * `SCS_PCT_SCALE;
        hiX = $signed({{34{hiLim_ff[31]}}, hiLim_ff}) * $signed({34'h0, ref_ff});
        loX = $signed({{34{loLim_ff[31]}}, loLim_ff}) * $signed({34'h0, ref_ff});
        if (modePct_ff) begin
            isLow = devX < loX;
            isHigh = devX > hiX;
        end else begin
            isLow = meas_ff < loLim_ff;
            isHigh = meas_ff > hiLim_ff;
        end
    end

    // ==========================================
    // Channel sequencer
    always_comb begin
        nxt_seq = seq_ff;
        nxt_chan = chan_ff;
        nxt_msCnt = msCnt_ff;
        nxt_cyc = cyc_ff;
        nxt_meas = meas_ff;
        nxt_req = req_ff;
        nxt_measReq = 1'b0;
        nxt_word = word_ff;
        nxt_grade = grade_ff;
        case (seq_ff)
            SQ_IDLE: begin
                if (enable_ff && (trigEvt || manStart)) begin
                    nxt_seq = SQ_DELAY;
                    nxt_chan = 7'h0;
                    nxt_msCnt = 15'h0;
                    nxt_cyc = '0;
                end
            end
            SQ_DELAY: begin
                if (cyc_ff == CYC_W'(CYC_PER_MS - 1)) begin
                    nxt_cyc = '0;
                    nxt_msCnt = msCnt_ff + 15'h1;
                    if (msCnt_ff == delayMs_ff - 15'h1) begin
                        nxt_seq = SQ_MEAS;
                        nxt_measReq = 1'b1;
                    end
                end else begin
                    nxt_cyc = cyc_ff + CYC_W'(1);
                end
            end
            SQ_MEAS: begin
                if (measValid) begin
                    nxt_meas = measData;
                    nxt_seq = SQ_GRADE;
                end
            end
            SQ_GRADE: begin
                nxt_grade[0] = !isLow && !isHigh;
                nxt_grade[1] = isLow;
                nxt_grade[2] = isHigh && !isLow;
                nxt_seq = SQ_SEND;
            end
            SQ_SEND: begin
                nxt_word = {chan_ff == chanCnt_ff - 7'h1, nxt_grade, 1'b1};
                nxt_word[3:1] = grade_ff;
                nxt_req = ~req_ff;
                nxt_seq = SQ_WAIT;
            end
            SQ_WAIT: begin
                if (!pending) begin
                    if (chan_ff == chanCnt_ff - 7'h1) begin
                        nxt_seq = SQ_IDLE;
                    end else begin
                        nxt_chan = chan_ff + 7'h1;
                        nxt_msCnt = 15'h0;
                        nxt_cyc = '0;
                        nxt_seq = SQ_DELAY;
                    end
                end
            end
            default: nxt_seq = SQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seq_ff <= SQ_IDLE;
            chan_ff <= 7'h0;
            msCnt_ff <= 15'h0;
            cyc_ff <= '0;
            meas_ff <= 32'h0;
            req_ff <= 1'b0;
            measReq_ff <= 1'b0;
            word_ff <= 5'h0;
            grade_ff <= 3'h0;
        end else begin
            seq_ff <= nxt_seq;
            chan_ff <= nxt_chan;
            msCnt_ff <= nxt_msCnt;
            cyc_ff <= nxt_cyc;
            meas_ff <= nxt_meas;
            req_ff <= nxt_req;
            measReq_ff <= nxt_measReq;
            word_ff <= nxt_word;
            grade_ff <= nxt_grade;
        end
    end

    assign measReq = measReq_ff;
    assign measChan = chan_ff;

    // ==========================================
    // Handler link, linkClk domain
    logic pinS1_ff, pinS2_ff, pinPrev_ff;
    logic enS1_ff, enS2_ff, fallS1_ff, fallS2_ff;
    logic reqS1_ff, reqS2_ff;
    logic nxt_trigTgl, nxt_ackTgl;
    scs_lnk_e lnk_ff, nxt_lnk;
    logic [3:0] hold_ff, nxt_hold;
    logic [4:0] out_ff, nxt_out;
    logic grpClk_ff, nxt_grpClk;
    logic scan_done_pulse_ff, nxt_scan_done_pulse;
    logic edgeSeen;

    always_ff @(posedge linkClk or negedge resetn) begin
        if (!resetn) begin
            pinS1_ff <= 1'b0;
            pinS2_ff <= 1'b0;
            enS1_ff <= 1'b0;
            enS2_ff <= 1'b0;
            fallS1_ff <= 1'b0;
            fallS2_ff <= 1'b0;
            reqS1_ff <= 1'b0;
            reqS2_ff <= 1'b0;
        end else begin
            pinS1_ff <= trigPin;
            pinS2_ff <= pinS1_ff;
            enS1_ff <= enable_ff;
            enS2_ff <= enS1_ff;
            fallS1_ff <= fallEdge_ff;
            fallS2_ff <= fallS1_ff;
            reqS1_ff <= req_ff;
            reqS2_ff <= reqS1_ff;
        end
    end

    always_comb begin
        edgeSeen = fallS2_ff ? (pinPrev_ff && !pinS2_ff) : (!pinPrev_ff && pinS2_ff);
        nxt_trigTgl = trigTgl_ff ^ (edgeSeen && enS2_ff);
        nxt_ackTgl = ackTgl_ff;
        nxt_lnk = lnk_ff;
        nxt_hold = hold_ff;
        nxt_out = out_ff;
        nxt_grpClk = 1'b0;
        nxt_scan_done_pulse = 1'b0;
        case (lnk_ff)
            LK_IDLE: begin
                if (reqS2_ff != ackTgl_ff) begin
                    nxt_out = word_ff;
                    nxt_hold = 4'h0;
                    nxt_lnk = LK_SETTLE;
                end
            end
            LK_SETTLE: begin
                nxt_hold = hold_ff + 4'h1;
                if (hold_ff == `SCS_LINK_HOLD - 4'h1) begin
                    nxt_hold = 4'h0;
                    nxt_grpClk = 1'b1;
                    nxt_lnk = LK_CLKHI;
                end
            end
            LK_CLKHI: begin
                nxt_hold = hold_ff + 4'h1;
                nxt_grpClk = 1'b1;
                if (hold_ff == `SCS_LINK_HOLD - 4'h1) begin
                    nxt_hold = 4'h0;
                    nxt_grpClk = 1'b0;
                    nxt_lnk = LK_CLKLO;
                end
            end
            LK_CLKLO: begin
                nxt_hold = hold_ff + 4'h1;
                if (hold_ff == `SCS_LINK_HOLD - 4'h1) begin
                    nxt_hold = 4'h0;
                    if (out_ff[4]) begin
                        nxt_scan_done_pulse = 1'b1;
                        nxt_lnk = LK_SCAN_DONE_PULSE;
                    end else begin
                        nxt_lnk = LK_ACK;
                    end
                end
            end
            LK_SCAN_DONE_PULSE: begin
                nxt_hold = hold_ff + 4'h1;
                nxt_scan_done_pulse = 1'b1;
                if (hold_ff == `SCS_LINK_HOLD - 4'h1) begin
                    nxt_scan_done_pulse = 1'b0;
                    nxt_out[0] = 1'b0;
                    nxt_lnk = LK_ACK;
                end
            end
            LK_ACK: begin
                nxt_ackTgl = reqS2_ff;
                nxt_lnk = LK_IDLE;
            end
            default: nxt_lnk = LK_IDLE;
        endcase
    end

    always_ff @(posedge linkClk or negedge resetn) begin
        if (!resetn) begin
            pinPrev_ff <= 1'b0;
            trigTgl_ff <= 1'b0;
            ackTgl_ff <= 1'b0;
            lnk_ff <= LK_IDLE;
            hold_ff <= 4'h0;
            out_ff <= 5'h0;
            grpClk_ff <= 1'b0;
            scan_done_pulse_ff <= 1'b0;
        end else begin
            pinPrev_ff <= pinS2_ff;
            trigTgl_ff <= nxt_trigTgl;
            ackTgl_ff <= nxt_ackTgl;
            lnk_ff <= nxt_lnk;
            hold_ff <= nxt_hold;
            out_ff <= nxt_out;
            grpClk_ff <= nxt_grpClk;
            scan_done_pulse_ff <= nxt_scan_done_pulse;
        end
    end

    // Pins released to other functions while scan is off
    assign scanOe = enS2_ff;
    assign relayOut = enS2_ff & out_ff[0];
    assign passOut = enS2_ff & out_ff[1];
    assign lowOut = enS2_ff & out_ff[2];
    assign highOut = enS2_ff & out_ff[3];
    assign groupClk = enS2_ff & grpClk_ff;
    assign scanDonePulse = enS2_ff & scan_done_pulse_ff;

endmodule : scs_scan_seq

// *** verif/scs_handler_model.sv ***
// Handler fixture model: drives the trigger and records each output group
`timescale 1ns/1ns
module scs_handler_model (
    // Link clock and reset
    input wire logic linkClk,
    input wire logic resetn,
    // Group outputs
    input wire logic relayOut,
    input wire logic passOut,
    input wire logic lowOut,
    input wire logic highOut,
    input wire logic groupClk,
    input wire logic scanDonePulse,
    // Trigger
    output logic trigPin
);
    logic idleLvl = 1'b0;
    logic gPrev;
    logic sPrev;
    logic [3:0] grades [256];
    int grpCnt = 0;
    int doneCnt = 0;

    initial trigPin = 1'b0;

    // Leading edge away from idle level
    task pulse();
        @(posedge linkClk);
        trigPin <= ~idleLvl;
        repeat (4) @(posedge linkClk);
        trigPin <= idleLvl;
    endtask : pulse

    task set_idle(input logic lvl);
        @(posedge linkClk);
        idleLvl = lvl;
        trigPin <= lvl;
    endtask : set_idle

    // Group captured as its clock rises
    always @(posedge linkClk or negedge resetn) begin
        if (!resetn) begin
            gPrev <= 1'b0;
            sPrev <= 1'b0;
        end else begin
            gPrev <= groupClk;
            sPrev <= scanDonePulse;
            if (groupClk && !gPrev) begin
                grades[grpCnt[7:0]] <= {relayOut, passOut, lowOut, highOut};
                grpCnt <= grpCnt + 1;
            end
            if (scanDonePulse && !sPrev) begin
                doneCnt <= doneCnt + 1;
            end
        end
    end
endmodule : scs_handler_model

// *** verif/scs_scan_seq_checker.sv ***
// Assertion checker for the scan compare sequencer ports
`timescale 1ns/1ns
module scs_scan_seq_checker (
    // Clocks and reset
    input wire logic clk,
    input wire logic linkClk,
    input wire logic resetn,
    // Front end
    input wire logic measReq,
    input wire logic [6:0] measChan,
    // Handler link
    input wire logic scanOe,
    input wire logic relayOut,
    input wire logic passOut,
    input wire logic lowOut,
    input wire logic highOut,
    input wire logic groupClk,
    input wire logic scanDonePulse
);
    // ==========================================
    // Link side
    AST_OE_GATE: assert property (@(posedge linkClk) disable iff (!resetn)
        !scanOe |-> !(relayOut | passOut | lowOut | highOut | groupClk | scanDonePulse))
        else $error("scan pins driven while disabled");
    AST_GCLK_WIDTH: assert property (@(posedge linkClk) disable iff (!resetn)
        $rose(groupClk) |-> groupClk [*4] ##1 !groupClk)
        else $error("group clock width wrong");
    AST_SCAN_DONE_PULSE_WIDTH: assert property (@(posedge linkClk) disable iff (!resetn)
        $rose(scanDonePulse) |-> scanDonePulse [*4] ##1 !scanDonePulse)
        else $error("done strobe width wrong");
    AST_NO_OVERLAP: assert property (@(posedge linkClk) disable iff (!resetn)
        !(groupClk && scanDonePulse))
        else $error("strobe overlaps group clock");
    AST_STABLE_GRP: assert property (@(posedge linkClk) disable iff (!resetn)
        groupClk |-> $stable({relayOut, passOut, lowOut, highOut}))
        else $error("group outputs moved under clock");
    AST_RELAY_GRP: assert property (@(posedge linkClk) disable iff (!resetn)
        groupClk |-> relayOut)
        else $error("relay low during group");
    AST_RELAY_END: assert property (@(posedge linkClk) disable iff (!resetn)
        $fell(scanDonePulse) |-> !relayOut)
        else $error("relay kept after done strobe");
    AST_GRADE_ONE: assert property (@(posedge linkClk) disable iff (!resetn)
        $rose(groupClk) |-> $onehot({passOut, lowOut, highOut}))
        else $error("group without single grade");
    AST_GRADE_EXCL: assert property (@(posedge linkClk) disable iff (!resetn)
        $onehot0({passOut, lowOut, highOut}))
        else $error("grades not exclusive");
    // ==========================================
    // System side
    AST_MEAS_PULSE: assert property (@(posedge clk) disable iff (!resetn)
        measReq |=> !measReq)
        else $error("measure request too long");
    AST_MEAS_CHAN: assert property (@(posedge clk) disable iff (!resetn)
        measReq |-> measChan <= 7'h63)
        else $error("channel index out of range");
    COV_GROUP: cover property (@(posedge linkClk) disable iff (!resetn) $rose(groupClk));
    COV_DONE: cover property (@(posedge linkClk) disable iff (!resetn) $rose(scanDonePulse));
    COV_MEAS: cover property (@(posedge clk) disable iff (!resetn) measReq);
endmodule : scs_scan_seq_checker

bind scs_scan_seq scs_scan_seq_checker chk (.clk, .linkClk, .resetn, .measReq, .measChan,
    .scanOe, .relayOut, .passOut, .lowOut, .highOut, .groupClk, .scanDonePulse);

// *** verif/tb.sv ***
// Self-checking bench of the scan compare sequencer
`timescale 1ns/1ns
`include "scs_cfg.svh"
module tb;
    logic clk, linkClk, resetn, regWr, regRd, measReq, measValid, trigPin, scanOe;
    logic relayOut, passOut, lowOut, highOut, groupClk, scanDonePulse;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData, measData;
    logic [6:0] measChan;
    logic [31:0] measTab [4];
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int g0;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        linkClk = 1'b0;
        #7;
        forever #6 linkClk = ~linkClk;
    end

    scs_scan_seq #(.CYC_PER_MS(1)) dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .measReq(measReq), .measChan(measChan), .measData(measData), .measValid(measValid),
        .linkClk(linkClk), .trigPin(trigPin), .scanOe(scanOe), .relayOut(relayOut),
        .passOut(passOut), .lowOut(lowOut), .highOut(highOut), .groupClk(groupClk),
        .scanDonePulse(scanDonePulse));

    scs_handler_model hm (.linkClk(linkClk), .resetn(resetn), .relayOut(relayOut),
        .passOut(passOut), .lowOut(lowOut), .highOut(highOut), .groupClk(groupClk),
        .scanDonePulse(scanDonePulse), .trigPin(trigPin));

    // Front end answers each request one cycle later
    always @(posedge clk) begin
        measValid <= measReq;
        if (measReq) begin
            measData <= measTab[measChan[1:0]];
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            give_verdict();
        end
    end

    task give_verdict();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : reg_wr

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(regRdData & m, exp);
    endtask : rd_chk

    task wait_done(input int n);
        for (int i = 0; i < 8000 && hm.doneCnt < n; i++) @(posedge clk);
        repeat (20) @(posedge clk);
        chk(hm.doneCnt, n);
    endtask : wait_done

    task check_grades(input logic [15:0] exp);
        for (int i = 0; i < 4; i++) chk({28'h0, hm.grades[g0 + i]}, {28'h0, exp[15-4*i -: 4]});
    endtask : check_grades

    task t_reset();
        rd_chk(`SCS_OFS_CTRL, 32'h0, '1);
        rd_chk(`SCS_OFS_CHANCNT, 32'h64, '1);
        rd_chk(`SCS_OFS_DELAY, 32'h190, '1);
        rd_chk(`SCS_OFS_REF, 32'h0, '1);
        rd_chk(`SCS_OFS_HILIM, 32'h0, '1);
        rd_chk(`SCS_OFS_LOLIM, 32'h0, '1);
        rd_chk(`SCS_OFS_STATUS, 32'h0, '1);
        rd_chk(8'h1c, 32'h0, '1);
        $display("t_reset done");
    endtask : t_reset

    task t_clamp();
        reg_wr(`SCS_OFS_CHANCNT, 32'h0);
        rd_chk(`SCS_OFS_CHANCNT, 32'h1, '1);
        reg_wr(`SCS_OFS_CHANCNT, 32'h7f);
        rd_chk(`SCS_OFS_CHANCNT, 32'h64, '1);
        reg_wr(`SCS_OFS_DELAY, 32'h64);
        rd_chk(`SCS_OFS_DELAY, 32'h190, '1);
        reg_wr(`SCS_OFS_DELAY, 32'h7fff);
        rd_chk(`SCS_OFS_DELAY, 32'h7530, '1);
        reg_wr(`SCS_OFS_DELAY, 32'h190);
        $display("t_clamp done");
    endtask : t_clamp

    task t_mode();
        reg_wr(`SCS_OFS_CTRL, 32'h4);
        rd_chk(`SCS_OFS_CTRL, 32'h4, '1);
        reg_wr(`SCS_OFS_CTRL, 32'h4);
        rd_chk(`SCS_OFS_CTRL, 32'h0, '1);
        hm.pulse();
        repeat (50) @(posedge clk);
        chk(scanOe, 1'b0);
        rd_chk(`SCS_OFS_STATUS, 32'h0, 32'h1);
        $display("t_mode done");
    endtask : t_mode

    task t_abs();
        measTab = '{32'd99, 32'd100, 32'd200, 32'd201};
        reg_wr(`SCS_OFS_HILIM, 32'd200);
        reg_wr(`SCS_OFS_LOLIM, 32'd100);
        reg_wr(`SCS_OFS_CHANCNT, 32'd4);
        reg_wr(`SCS_OFS_CTRL, 32'h1);
        repeat (5) @(posedge clk);
        chk(scanOe, 1'b1);
        g0 = hm.grpCnt;
        hm.pulse();
        repeat (100) @(posedge clk);
        rd_chk(`SCS_OFS_STATUS, 32'h1, 32'h1);
        hm.pulse();
        wait_done(1);
        chk(hm.grpCnt - g0, 4);
        check_grades(16'ha_c_c_9);
        chk(relayOut, 1'b0);
        repeat (1000) @(posedge clk);
        chk(hm.grpCnt - g0, 4);
        $display("t_abs done");
    endtask : t_abs

    task t_pct();
        reg_wr(`SCS_OFS_CTRL, 32'h0);
        hm.set_idle(1'b1);
        measTab = '{32'd949, 32'd950, 32'd1050, 32'd1051};
        reg_wr(`SCS_OFS_REF, 32'd1000);
        reg_wr(`SCS_OFS_HILIM, 32'd5);
        reg_wr(`SCS_OFS_LOLIM, 32'hffff_fffb);
        reg_wr(`SCS_OFS_CTRL, 32'h7);
        rd_chk(`SCS_OFS_CTRL, 32'h7, 32'hf);
        g0 = hm.grpCnt;
        hm.pulse();
        wait_done(2);
        chk(hm.grpCnt - g0, 4);
        check_grades(16'ha_c_c_9);
        rd_chk(`SCS_OFS_STATUS, 32'h8, 32'hf);
        $display("t_pct done");
    endtask : t_pct

    task t_manual();
        reg_wr(`SCS_OFS_CHANCNT, 32'd1);
        g0 = hm.grpCnt;
        reg_wr(`SCS_OFS_CTRL, 32'hb);
        wait_done(3);
        chk(hm.grpCnt - g0, 1);
        chk({28'h0, hm.grades[g0]}, 32'ha);
        $display("t_manual done");
    endtask : t_manual

    initial begin
        resetn = 1'b0;
        regAddr = 8'h0;
        regWrData = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        measData = 32'h0;
        measValid = 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_clamp();
        t_mode();
        t_abs();
        t_pct();
        t_manual();
        give_verdict();
    end
endmodule : tb
